// >>> pip_pkg.sv
package pip_pkg;

  // Pin vector layout: port 0 at 7:0, port 1 at 15:8, port 2 at 20:16
  localparam int NPINS    = 21;
  localparam int P1_BASE  = 8;
  localparam int P2_BASE  = 16;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_PIN_IN   = 8'h00;
  localparam logic [7:0] OFS_FUNC_SEL = 8'h04;
  localparam logic [7:0] OFS_DIR_SEL  = 8'h08;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h0c;
  localparam logic [7:0] OFS_P1_MASK  = 8'h10;
  localparam logic [7:0] OFS_GRP_EN   = 8'h14;
  localparam logic [7:0] OFS_FLAGS    = 8'h18;
  localparam logic [7:0] OFS_CPU_FLG  = 8'h1c;
  localparam logic [7:0] OFS_LOC_CTRL = 8'h20;
  localparam logic [7:0] OFS_ADC_CFG  = 8'h24;
  localparam logic [7:0] OFS_SLEEP    = 8'h28;
  localparam logic [7:0] OFS_OUT_DATA = 8'h2c;
  localparam logic [7:0] OFS_IN_MODE  = 8'h30;

  // Interrupt control fields
  localparam int IC_POL_P0 = 0;
  localparam int IC_POL_P1 = 1;
  localparam int IC_POL_P2 = 2;
  localparam int IC_NIB_LO = 3;
  localparam int IC_NIB_HI = 4;
  localparam int IC_P2_EN  = 5;

  // Location control fields
  localparam int LC_SA_LOC  = 0;
  localparam int LC_SB_LOC  = 1;
  localparam int LC_T1_LOC  = 2;
  localparam int LC_T3_LOC  = 3;
  localparam int LC_T4_LOC  = 4;
  localparam int LC_AUD_LOC = 5;
  localparam int LC_PREC_LO = 6;
  localparam int LC_PRI_LO  = 8;
  localparam int LC_SA_NFC  = 12;
  localparam int LC_SB_NFC  = 13;
  localparam int LC_AUD_EN  = 14;
  localparam int LC_USE_LO  = 24;

  // Reset values
  localparam logic [20:0] RST_OUT_DATA = 21'h1fffff;
  localparam logic [20:0] NO_PULL_PINS = 21'h000300;

  // Pin location lookup per peripheral and alternative
  localparam logic [20:0] SA_ALT1  = 21'h00003c;
  localparam logic [20:0] SA_ALT2  = 21'h003c00;
  localparam logic [20:0] SA_NFC1  = 21'h000030;
  localparam logic [20:0] SA_NFC2  = 21'h000c00;
  localparam logic [20:0] SB_ALT1  = 21'h00003c;
  localparam logic [20:0] SB_ALT2  = 21'h00f000;
  localparam logic [20:0] SB_NFC1  = 21'h00000c;
  localparam logic [20:0] SB_NFC2  = 21'h003000;
  localparam logic [20:0] T1_ALT1  = 21'h00001c;
  localparam logic [20:0] T1_ALT2  = 21'h000700;
  localparam logic [20:0] T3_ALT1  = 21'h001800;
  localparam logic [20:0] T3_ALT2  = 21'h00c000;
  localparam logic [20:0] T4_ALT1  = 21'h000300;
  localparam logic [20:0] T4_ALT2  = 21'h090000;
  localparam logic [20:0] AUD_ALT1 = 21'h00c003;
  localparam logic [20:0] AUD_ALT2 = 21'h0f0000;
  localparam logic [20:0] XOSC_PIN = 21'h180000;
  localparam logic [20:0] DBG_PIN  = 21'h060000;

  // DMA trigger pins
  localparam int DMA_A_PIN = 1;
  localparam int DMA_B_PIN = 11;

  localparam logic [1:0] SLEEP_ACTIVE = 2'h0;

  typedef enum logic [2:0] {
    OWN_GPIO  = 3'h0,
    OWN_SA    = 3'h1,
    OWN_SB    = 3'h2,
    OWN_T1    = 3'h3,
    OWN_T3    = 3'h4,
    OWN_T4    = 3'h5,
    OWN_AUD   = 3'h6,
    OWN_FIXED = 3'h7
  } pip_owner_t;

  typedef struct packed {
    logic [NPINS-1:0] o;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] pull;
  } pip_pin_bus_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [DATA_W-1:0] pwdata;
  } pip_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } pip_apb_rsp_t;

endpackage

// >>> pip_port_ctrl.sv
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// - Detect pin events on selectable edge
// - Edge polarity per port in control register
// - One group interrupt enable per port
// - Individual enable for each port 1 pin
// - Port 0 low and high nibble enables
// - One shared enable for port 2 pins
// - Status flag set regardless of enables
// - CPU flag only with a relevant enable
// - Sleep mode nonzero blocks port interrupts
// - Trigger A on port 0 pin 1 rise
// - Trigger B on port 1 pin 3 fall
// - Triggers only from general purpose inputs
// - Select bit one routes pin to peripheral
// - Two location alternatives per peripheral
// - Precedence 00 favours serial unit A
// - Serial A UART frees port 0 pins 4,5
// - Port 1 bits 3,2,0 zero favour A
// - Serial A UART frees port 1 pins
// - Reset: inputs with pull-up, two without
// - Precedence 01 favours serial unit B
// - Precedence 10/11 favour timer 1
module pip_port_ctrl (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire pip_pkg::pip_apb_req_t             apb_req,
  output      pip_pkg::pip_apb_rsp_t             apb_rsp,
  input  wire logic [pip_pkg::NPINS-1:0]         pin_i,
  input  wire logic                              dbg_active,
  input  wire logic                              xosc_active,
  output      pip_pkg::pip_pin_bus_t             pins,
  output      pip_pkg::pip_owner_t [pip_pkg::NPINS-1:0] pin_owner,
  output      logic [2:0]                        cpu_irq,
  output      logic                              dma_trig_a,
  output      logic                              dma_trig_b
);
  import pip_pkg::*;

  typedef struct packed {
    logic [NPINS-1:0]             sync1;
    logic [NPINS-1:0]             sync2;
    logic [NPINS-1:0]             prev;
    logic [NPINS-1:0]             sel;
    logic [NPINS-1:0]             dir;
    logic [NPINS-1:0]             outv;
    logic [NPINS-1:0]             inmode;
    logic [5:0]                   irq_ctrl;
    logic [7:0]                   p1_mask;
    logic [2:0]                   grp_en;
    logic [NPINS-1:0]             flags;
    logic [2:0]                   cpu_flg;
    logic [DATA_W-1:0]            loc;
    logic [7:0]                   adc_cfg;
    logic [1:0]                   sleep;
    pip_apb_rsp_t                 rsp;
    pip_pin_bus_t                 pins;
    pip_owner_t [NPINS-1:0]       owner;
    logic [2:0]                   irq;
    logic                         dma_a;
    logic                         dma_b;
  } pip_state_t;

  // Picks the claimant with the lowest weight; weights are 3 bits each
  function automatic pip_owner_t resolve(input logic [4:0]  claim,
                                         input logic [14:0] wts);
    pip_owner_t best;
    logic [2:0] best_w;
    best   = OWN_GPIO;
    best_w = 3'h7;
    for (int k = 0; k < 5; k++) begin
      if (claim[k] && (wts[k*3 +: 3] < best_w)) begin
        best_w = wts[k*3 +: 3];
        best   = pip_owner_t'(3'(k + 1));
      end
    end
    return best;
  endfunction

  pip_state_t r_reg;
  pip_state_t r_next;

  logic [NPINS-1:0] rise;
  logic [NPINS-1:0] fall;
  logic [NPINS-1:0] cond;
  logic [NPINS-1:0] pin_en;
  logic [NPINS-1:0] pol_vec;
  logic [NPINS-1:0] m_sa;
  logic [NPINS-1:0] m_sb;
  logic [NPINS-1:0] m_t1;
  logic [NPINS-1:0] m_t3;
  logic [NPINS-1:0] m_t4;
  logic [NPINS-1:0] m_aud;
  logic [NPINS-1:0] m_fixed;
  logic [14:0]      w_p0;
  logic [14:0]      w_p1;
  logic [1:0]       prec;
  logic [3:0]       pri;
  logic [2:0]       port_hit;
  logic             setup;
  logic             wr_acc;
  logic             mapped;
  logic [DATA_W-1:0] rd_val;

  // Edge detection on synchronised pins, input direction only
  always_comb begin
    pol_vec = {{5{r_reg.irq_ctrl[IC_POL_P2]}},
               {8{r_reg.irq_ctrl[IC_POL_P1]}},
               {8{r_reg.irq_ctrl[IC_POL_P0]}}};
    rise = r_reg.sync2 & ~r_reg.prev;
    fall = ~r_reg.sync2 & r_reg.prev;
    cond = ((pol_vec & fall) | (~pol_vec & rise)) & ~r_reg.dir;
    pin_en = {{5{r_reg.irq_ctrl[IC_P2_EN]}},
              r_reg.p1_mask,
              {4{r_reg.irq_ctrl[IC_NIB_HI]}},
              {4{r_reg.irq_ctrl[IC_NIB_LO]}}};
  end

  // Location masks and precedence weights
  always_comb begin
    m_sa  = r_reg.loc[LC_SA_LOC] ? SA_ALT2 : SA_ALT1;
    m_sb  = r_reg.loc[LC_SB_LOC] ? SB_ALT2 : SB_ALT1;
    m_t1  = r_reg.loc[LC_T1_LOC] ? T1_ALT2 : T1_ALT1;
    m_t3  = r_reg.loc[LC_T3_LOC] ? T3_ALT2 : T3_ALT1;
    m_t4  = r_reg.loc[LC_T4_LOC] ? T4_ALT2 : T4_ALT1;
    m_aud = r_reg.loc[LC_AUD_LOC] ? AUD_ALT2 : AUD_ALT1;
    // UART without flow control releases its handshake pins
    if (r_reg.loc[LC_SA_NFC]) begin
      m_sa = m_sa & ~(r_reg.loc[LC_SA_LOC] ? SA_NFC2 : SA_NFC1);
    end
    if (r_reg.loc[LC_SB_NFC]) begin
      m_sb = m_sb & ~(r_reg.loc[LC_SB_LOC] ? SB_NFC2 : SB_NFC1);
    end
    m_sa  = m_sa & {NPINS{r_reg.loc[LC_USE_LO]}};
    m_sb  = m_sb & {NPINS{r_reg.loc[LC_USE_LO + 1]}};
    m_t1  = m_t1 & {NPINS{r_reg.loc[LC_USE_LO + 2]}};
    m_t3  = m_t3 & {NPINS{r_reg.loc[LC_USE_LO + 3]}};
    m_t4  = m_t4 & {NPINS{r_reg.loc[LC_USE_LO + 4]}};
    m_aud = m_aud & {NPINS{r_reg.loc[LC_AUD_EN]}};
    m_fixed = ({NPINS{dbg_active}} & DBG_PIN)
            | ({NPINS{xosc_active}} & XOSC_PIN)
            | {13'h0000, r_reg.adc_cfg};
    prec = r_reg.loc[LC_PREC_LO +: 2];
    pri  = r_reg.loc[LC_PRI_LO +: 4];
    // Port 0 weights, packed {t4,t3,t1,sb,sa}
    unique case (prec)
      2'h0: w_p0 = {3'h4, 3'h4, 3'h3, 3'h2, 3'h1};
      2'h1: w_p0 = {3'h4, 3'h4, 3'h3, 3'h1, 3'h2};
      2'h2: w_p0 = {3'h4, 3'h4, 3'h1, 3'h2, 3'h3};
      2'h3: w_p0 = {3'h4, 3'h4, 3'h1, 3'h3, 3'h2};
    endcase
    // Port 1 weights: serial A first unless bits move others ahead
    w_p1 = {3'h4, 3'h4, 3'h3, 3'h3, 3'h2};
    if (pri[3] && !pri[2]) begin
      w_p1[5:3] = 3'h1;
    end
    if (pri[2]) begin
      w_p1[11:9] = 3'h1;
    end
    if (pri[0]) begin
      w_p1[8:6] = 3'h1;
    end
    if (pri[1]) begin
      w_p1[14:12] = 3'h1;
      w_p1[8:6]   = pri[0] ? 3'h2 : 3'h3;
    end
  end

  // APB decode and read mux
  always_comb begin
    setup  = apb_req.psel && !apb_req.penable && !r_reg.rsp.pready;
    wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite
             && r_reg.rsp.pready && !r_reg.rsp.pslverr;
    mapped = 1'b1;
    rd_val = '0;
    unique case (apb_req.paddr)
      OFS_PIN_IN:   rd_val[NPINS-1:0] = r_reg.sync2;
      OFS_FUNC_SEL: rd_val[NPINS-1:0] = r_reg.sel;
      OFS_DIR_SEL:  rd_val[NPINS-1:0] = r_reg.dir;
      OFS_IRQ_CTRL: rd_val[5:0]       = r_reg.irq_ctrl;
      OFS_P1_MASK:  rd_val[7:0]       = r_reg.p1_mask;
      OFS_GRP_EN:   rd_val[2:0]       = r_reg.grp_en;
      OFS_FLAGS:    rd_val[NPINS-1:0] = r_reg.flags;
      OFS_CPU_FLG:  rd_val[2:0]       = r_reg.cpu_flg;
      OFS_LOC_CTRL: rd_val            = r_reg.loc;
      OFS_ADC_CFG:  rd_val[7:0]       = r_reg.adc_cfg;
      OFS_SLEEP:    rd_val[1:0]       = r_reg.sleep;
      OFS_OUT_DATA: rd_val[NPINS-1:0] = r_reg.outv;
      OFS_IN_MODE:  rd_val[NPINS-1:0] = r_reg.inmode;
      default:      mapped            = 1'b0;
    endcase
  end

  // Next-state logic
  always_comb begin
    r_next = r_reg;
    // Two-flop synchroniser, then edge history
    r_next.sync1 = pin_i;
    r_next.sync2 = r_reg.sync1;
    r_next.prev  = r_reg.sync2;

    // APB answer: one access cycle, error on unmapped offsets
    r_next.rsp.pready  = setup;
    r_next.rsp.pslverr = setup && !mapped;
    if (setup) begin
      r_next.rsp.prdata = apb_req.pwrite ? '0 : rd_val;
    end

    // Register writes at the completing access edge
    if (wr_acc) begin
      unique case (apb_req.paddr)
        OFS_FUNC_SEL: r_next.sel      = apb_req.pwdata[NPINS-1:0];
        OFS_DIR_SEL:  r_next.dir      = apb_req.pwdata[NPINS-1:0];
        OFS_IRQ_CTRL: r_next.irq_ctrl = apb_req.pwdata[5:0];
        OFS_P1_MASK:  r_next.p1_mask  = apb_req.pwdata[7:0];
        OFS_GRP_EN:   r_next.grp_en   = apb_req.pwdata[2:0];
        OFS_FLAGS:    r_next.flags    = r_reg.flags
                                        & apb_req.pwdata[NPINS-1:0];
        OFS_CPU_FLG:  r_next.cpu_flg  = r_reg.cpu_flg
                                        & apb_req.pwdata[2:0];
        OFS_LOC_CTRL: r_next.loc      = apb_req.pwdata;
        OFS_ADC_CFG:  r_next.adc_cfg  = apb_req.pwdata[7:0];
        OFS_SLEEP:    r_next.sleep    = apb_req.pwdata[1:0];
        OFS_OUT_DATA: r_next.outv     = apb_req.pwdata[NPINS-1:0];
        OFS_IN_MODE:  r_next.inmode   = apb_req.pwdata[NPINS-1:0]
                                        & ~NO_PULL_PINS;
        default:      r_next.sel      = r_reg.sel;
      endcase
    end

    // Status flags: a new event wins over a clearing write
    r_next.flags = r_next.flags | cond;

    // CPU flags follow any enabled pending flag while awake
    port_hit[0] = |(r_next.flags[7:0] & pin_en[7:0]);
    port_hit[1] = |(r_next.flags[15:8] & pin_en[15:8]);
    port_hit[2] = |(r_next.flags[20:16] & pin_en[20:16]);
    if (r_reg.sleep == SLEEP_ACTIVE) begin
      r_next.cpu_flg = r_next.cpu_flg | port_hit;
    end
    r_next.irq = r_reg.cpu_flg & r_reg.grp_en;

    // DMA triggers from general purpose inputs only
    r_next.dma_a = rise[DMA_A_PIN] && !r_reg.sel[DMA_A_PIN]
                   && !r_reg.dir[DMA_A_PIN];
    r_next.dma_b = fall[DMA_B_PIN] && !r_reg.sel[DMA_B_PIN]
                   && !r_reg.dir[DMA_B_PIN];

    // Pin ownership per pin
    for (int i = 0; i < NPINS; i++) begin
      if (m_fixed[i]) begin
        r_next.owner[i] = OWN_FIXED;
      end else if (m_aud[i]) begin
        r_next.owner[i] = OWN_AUD;
      end else if (!r_reg.sel[i]) begin
        r_next.owner[i] = OWN_GPIO;
      end else begin
        r_next.owner[i] = resolve({m_t4[i], m_t3[i], m_t1[i],
                                   m_sb[i], m_sa[i]},
                                  (i < P1_BASE) ? w_p0 :
                                  (i < P2_BASE) ? w_p1 :
                                  15'h4c8a);
      end
    end

    // Pad drive: general purpose outputs only
    r_next.pins.o    = r_reg.outv;
    r_next.pins.oe   = r_reg.dir & ~r_reg.sel & ~m_fixed & ~m_aud;
    r_next.pins.pull = ~r_reg.inmode & ~NO_PULL_PINS;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg           <= '0;
      // Edge history starts at the pulled-up idle level, no false edge
      r_reg.sync1     <= '1;
      r_reg.sync2     <= '1;
      r_reg.prev      <= '1;
      r_reg.outv      <= RST_OUT_DATA;
      r_reg.pins.o    <= RST_OUT_DATA;
      r_reg.pins.pull <= ~NO_PULL_PINS;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flops
  assign apb_rsp    = r_reg.rsp;
  assign pins       = r_reg.pins;
  assign pin_owner  = r_reg.owner;
  assign cpu_irq    = r_reg.irq;
  assign dma_trig_a = r_reg.dma_a;
  assign dma_trig_b = r_reg.dma_b;

endmodule

// >>> pip_port_ctrl_chk.sv
`timescale 1ns/1ps

module pip_port_ctrl_chk (
  input wire logic                                  pclk,
  input wire logic                                  presetn,
  input wire pip_pkg::pip_apb_req_t                 apb_req,
  input wire pip_pkg::pip_apb_rsp_t                 apb_rsp,
  input wire logic [pip_pkg::NPINS-1:0]             pin_i,
  input wire logic                                  dbg_active,
  input wire logic                                  xosc_active,
  input wire pip_pkg::pip_pin_bus_t                 pins,
  input wire pip_pkg::pip_owner_t [pip_pkg::NPINS-1:0] pin_owner,
  input wire logic [2:0]                            cpu_irq,
  input wire logic                                  dma_trig_a,
  input wire logic                                  dma_trig_b
);
  import pip_pkg::*;

  // All checks on the bus clock, quiet during reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Setup cycle is answered in the first access cycle
  chk_ready_after_setup: assert property (
    apb_req.psel && !apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("pready missing after setup");
  chk_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  chk_err_with_ready: assert property (
    apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
    else $error("pslverr without pready or with data");
  chk_no_pull_pins: assert property (pins.pull[9:8] == 2'h0)
    else $error("pull enabled on pin without resistor");
  chk_dma_a_rise: assert property (
    dma_trig_a |-> $past(pin_i[1], 2) && !$past(pin_i[1], 5) && !pins.oe[1])
    else $error("trigger a without rise on input pin");
  chk_dma_b_fall: assert property (
    dma_trig_b |-> !$past(pin_i[11], 2) && $past(pin_i[11], 5)
      && !pins.oe[11])
    else $error("trigger b without fall on input pin");
  chk_dma_pulse_len: assert property (
    dma_trig_a || dma_trig_b |=> !dma_trig_a && !dma_trig_b)
    else $error("trigger pulse longer than one cycle");
  chk_dbg_owner: assert property (
    dbg_active && $past(dbg_active) && $past(presetn)
      |-> pin_owner[17] == OWN_FIXED && pin_owner[18] == OWN_FIXED)
    else $error("debug pins not owned by debug");
  chk_xosc_owner: assert property (
    xosc_active && $past(xosc_active) && $past(presetn)
      |-> pin_owner[19] == OWN_FIXED && pin_owner[20] == OWN_FIXED)
    else $error("crystal pins not owned by crystal");
endmodule

// >>> pip_pin_model.sv
`timescale 1ns/1ps

module pip_pin_model (
  input  wire logic                      pclk,
  input  wire pip_pkg::pip_pin_bus_t     pins,
  input  wire logic [pip_pkg::NPINS-1:0] ext_val,
  input  wire logic [pip_pkg::NPINS-1:0] ext_en,
  output      logic [pip_pkg::NPINS-1:0] pin_i
);
  import pip_pkg::*;

  logic [NPINS-1:0] last_reg;

  // Wire level: device drive, then outside drive, then pull-up
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (pins.oe[i])
        pin_i[i] = pins.o[i];
      else if (ext_en[i])
        pin_i[i] = ext_val[i];
      else if (pins.pull[i])
        pin_i[i] = 1'b1;
      else
        pin_i[i] = ~last_reg[i]; // Floating line never keeps its value
    end
  end

  // Last seen level, used when nobody drives
  always_ff @(posedge pclk) last_reg <= pin_i;
endmodule

// >>> pip_port_ctrl_tb.sv
`timescale 1ns/1ps

module pip_port_ctrl_tb;
  import pip_pkg::*;

  logic                   pclk;
  logic                   presetn;
  pip_apb_req_t           apb_req;
  pip_apb_rsp_t           apb_rsp;
  logic [NPINS-1:0]       pin_i;
  logic [NPINS-1:0]       ext_val;
  logic [NPINS-1:0]       ext_en;
  logic                   dbg_active;
  logic                   xosc_active;
  pip_pin_bus_t           pins;
  pip_owner_t [NPINS-1:0] pin_owner;
  logic [2:0]             cpu_irq;
  logic                   dma_trig_a;
  logic                   dma_trig_b;
  logic [31:0]            rd;
  logic                   err;
  int                     n_mismatch = 0;
  int                     n_tests = 0;
  int                     n_dma_a = 0;
  int                     n_dma_b = 0;
  // Interrupt cases: pin, control, port 1 mask, sleep, expected cpu flags
  int                     tp [7] = '{2, 6, 2, 13, 13, 12, 16};
  logic [31:0]            tc [7] = '{32'h8, 32'h10, 32'h10, 32'h0, 32'h0,
                                     32'h2, 32'h20};
  logic [31:0]            tm [7] = '{32'h0, 32'h0, 32'h0, 32'h20, 32'h10,
                                     32'h10, 32'h0};
  logic [31:0]            ts [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                                     32'h0, 32'h1};
  logic [31:0]            te [7] = '{32'h1, 32'h1, 32'h0, 32'h2, 32'h0,
                                     32'h2, 32'h0};
  // Ownership cases: location control, pin, expected owner
  logic [31:0]            lc [7] = '{32'h03000000, 32'h03000040,
                                     32'h06000080, 32'h050000c0,
                                     32'h03001000, 32'h05000005,
                                     32'h05001005};
  int                     op [7] = '{2, 2, 2, 2, 4, 10, 10};
  pip_owner_t             oe_x [7] = '{OWN_SA, OWN_SB, OWN_T1, OWN_T1,
                                       OWN_SB, OWN_SA, OWN_T1};

  pip_port_ctrl dut (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .pin_i(pin_i), .dbg_active(dbg_active), .xosc_active(xosc_active),
    .pins(pins), .pin_owner(pin_owner), .cpu_irq(cpu_irq),
    .dma_trig_a(dma_trig_a), .dma_trig_b(dma_trig_b));

  pip_pin_model u_pins (
    .pclk(pclk), .pins(pins), .ext_val(ext_val), .ext_en(ext_en),
    .pin_i(pin_i));

  // Bus clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Count trigger pulses
  always @(posedge pclk) begin
    if (dma_trig_a === 1'b1) n_dma_a++;
    if (dma_trig_b === 1'b1) n_dma_b++;
  end

  task automatic finish_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb_xfer(input logic w, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q,
                          output logic e);
    int n = 0;
    @(posedge pclk);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // Registered answer is settled mid-cycle and stands to the next edge
    do begin
      @(negedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      finish_test();
    end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    @(posedge pclk);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb_xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask

  // Move one outside pin and let the synchroniser settle
  task automatic set_pin(input int p, input logic v);
    @(posedge pclk);
    ext_val[p] <= v;
    repeat (6) @(posedge pclk);
  endtask

  initial begin
    apb_req = '0;
    ext_val = '1;
    ext_en = '1;
    dbg_active = 1'b0;
    xosc_active = 1'b0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    chk({11'h0, pins.pull}, 32'h1ffcff);
    chk({11'h0, pins.oe}, 32'h0);
    presetn <= 1'b1;
    rd_chk(OFS_OUT_DATA, 32'h1fffff);
    rd_chk(OFS_DIR_SEL, 32'h0);
    rd_chk(OFS_FUNC_SEL, 32'h0);
    rd_chk(OFS_IN_MODE, 32'h0);
    apb_xfer(1'b0, 8'h40, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    wr(OFS_PIN_IN, 32'h0);
    rd_chk(OFS_PIN_IN, 32'h1fffff);
    // Edges with rising polarity and no enables
    wr(OFS_FLAGS, 32'h0);
    set_pin(1, 1'b0);
    set_pin(11, 1'b0);
    rd_chk(OFS_FLAGS, 32'h0);
    set_pin(1, 1'b1);
    wr(OFS_FLAGS, 32'h1fffff);
    rd_chk(OFS_FLAGS, 32'h2);
    rd_chk(OFS_CPU_FLG, 32'h0);
    chk(n_dma_a, 32'h1);
    chk(n_dma_b, 32'h1);
    // Triggers refused on peripheral and output pins
    wr(OFS_FUNC_SEL, 32'h800);
    set_pin(11, 1'b1);
    set_pin(11, 1'b0);
    wr(OFS_FUNC_SEL, 32'h0);
    wr(OFS_OUT_DATA, 32'h1ffffd);
    wr(OFS_DIR_SEL, 32'h2);
    wr(OFS_OUT_DATA, 32'h1fffff);
    repeat (6) @(posedge pclk);
    wr(OFS_DIR_SEL, 32'h0);
    chk(n_dma_a, 32'h1);
    chk(n_dma_b, 32'h1);
    // Enable combinations, polarity and sleep
    for (int i = 0; i < 7; i++) begin
      wr(OFS_IRQ_CTRL, tc[i]);
      wr(OFS_P1_MASK, tm[i]);
      wr(OFS_GRP_EN, 32'h7);
      wr(OFS_SLEEP, ts[i]);
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_CPU_FLG, 32'h0);
      set_pin(tp[i], 1'b0);
      set_pin(tp[i], 1'b1);
      rd_chk(OFS_FLAGS, 32'h1 << tp[i]);
      rd_chk(OFS_CPU_FLG, te[i]);
      chk({29'h0, cpu_irq}, te[i]);
    end
    wr(OFS_SLEEP, 32'h0);
    // Pin ownership and precedence
    wr(OFS_FUNC_SEL, 32'h1fffff);
    dbg_active <= 1'b1;
    xosc_active <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wr(OFS_LOC_CTRL, lc[i]);
      repeat (2) @(posedge pclk);
      chk({29'h0, pin_owner[op[i]]}, {29'h0, oe_x[i]});
    end
    wr(OFS_ADC_CFG, 32'h1);
    repeat (2) @(posedge pclk);
    chk({29'h0, pin_owner[0]}, {29'h0, OWN_FIXED});
    chk({29'h0, pin_owner[17]}, {29'h0, OWN_FIXED});
    chk({29'h0, pin_owner[19]}, {29'h0, OWN_FIXED});
    wr(OFS_FUNC_SEL, 32'h0);
    wr(OFS_LOC_CTRL, 32'h03000000);
    repeat (2) @(posedge pclk);
    chk({29'h0, pin_owner[2]}, {29'h0, OWN_GPIO});
    finish_test();
  end
endmodule

bind pip_port_ctrl pip_port_ctrl_chk u_chk (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .pin_i(pin_i), .dbg_active(dbg_active), .xosc_active(xosc_active),
  .pins(pins), .pin_owner(pin_owner), .cpu_irq(cpu_irq),
  .dma_trig_a(dma_trig_a), .dma_trig_b(dma_trig_b));
